// ==== src/euart_top.sv ====
// Enhanced UART with APB registers
`timescale 1ns/100ps
`include "euart_params.svh"
module euart_top (
	input wire logic sys_clk_i, // CPU clock
	input wire logic srst_i, // Sync reset
	input wire logic psel_i, // APB select
	input wire logic penable_i, // APB enable
	input wire logic pwrite_i, // APB write
	input wire logic [11:0] paddr_i, // APB address
	input wire logic [31:0] pwdata_i, // APB write data
	output logic [31:0] prdata_o, // APB read data
	output logic pready_o, // APB ready
	output logic pslverr_o, // APB error
	input wire logic rxd_i, // Receive pin input
	output logic rxd_o, // Receive pin output
	output logic rxd_oe_o, // Receive pin enable
	output logic txd_o, // Transmit pin
	input wire logic t1_ovf_i, // Timer-1 overflow pulse
	output logic tx_irq_o, // Transmit event flag
	output logic rx_irq_o, // Receive event flag
	output logic break_rst_o // Break reset request
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] stat;
		logic [7:0] pwrc;
		logic [15:0] brg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		euart_pkg::euart_txst_e txst;
		logic [10:0] tx_sh;
		logic [3:0] tx_bits;
		logic [3:0] tx_ph;
		logic [8:0] tx_buf;
		logic tx_full;
		logic txd;
		euart_pkg::euart_rxst_e rxst;
		logic [9:0] rx_sh;
		logic [3:0] rx_bits;
		logic [3:0] rx_ph;
		logic [7:0] rx_data;
		logic rxd_prev;
		logic [3:0] brk_bits;
		logic [3:0] brk_ph;
		logic rxo;
		logic rxoe;
		logic brst;
	} st_s;
	st_s q, d;
	logic tick16;
	logic brg_tick;
	logic [1:0] mode;
	logic dbm;
	logic [3:0] nbits;
	logic wr;
	logic rd;
	logic wr_data;
	logic tx_done;
	logic rx_done;
	logic [10:0] frame;
	//----------------------------------------
	// Rate generation
	//----------------------------------------
	euart_brg u_brg (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.divisor_i(q.brg),
		.tick_o(brg_tick)
	);
	euart_rate u_rate (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.mode_i(mode),
		.halve_sel_i(q.pwrc[`EU_BIT_PWRC_HALVE]),
		.t1_sel_i(q.pwrc[`EU_BIT_PWRC_T1SEL]),
		.t1_ovf_i(t1_ovf_i),
		.brg_tick_i(brg_tick),
		.tick16_o(tick16)
	);
	assign mode = {q.ctrl[`EU_BIT_CTRL_MODE_HI], q.ctrl[`EU_BIT_CTRL_MODE_LO]};
	assign dbm = q.stat[`EU_BIT_STAT_DBM];
	// Frame bits after start: 8 for shift, 9 for 8-bit (data and stop), 10 for 9-bit (data, ninth and stop)
	assign nbits = (mode == 2'b00) ? 4'h8 : ((mode == 2'b01) ? 4'h9 : 4'hA);
	assign wr = psel_i & penable_i & pwrite_i & ~q.pready;
	assign rd = psel_i & penable_i & ~pwrite_i & ~q.pready;
	assign wr_data = wr & (paddr_i == `EU_ADDR_DATA);
	always_comb begin
		d = q;
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		tx_done = 1'b0;
		rx_done = 1'b0;
		frame = '0;
		//----------------------------------------
		// APB slave, one wait state
		//----------------------------------------
		if (psel_i & penable_i & ~q.pready) begin
			d.pready = 1'b1;
			d.prdata = 32'h0000_0000;
			unique case (paddr_i)
				`EU_ADDR_CTRL: begin
					if (wr) begin
						d.ctrl = pwdata_i[7:0];
						if (q.pwrc[`EU_BIT_PWRC_FEVIEW]) begin
							d.ctrl[`EU_BIT_CTRL_MODE_HI] = q.ctrl[`EU_BIT_CTRL_MODE_HI];
							if (~pwdata_i[7]) begin
								d.stat[`EU_BIT_STAT_FE] = 1'b0;
							end
						end
					end
					d.prdata[7:0] = q.ctrl;
					if (q.pwrc[`EU_BIT_PWRC_FEVIEW]) begin
						d.prdata[7] = q.stat[`EU_BIT_STAT_FE];
					end
				end
				`EU_ADDR_DATA: begin
					d.prdata[7:0] = q.rx_data;
				end
				`EU_ADDR_STAT: begin
					if (wr) begin
						d.stat = (pwdata_i[7:0] & q.stat) | (pwdata_i[7:0] & 8'hC0);
					end
					d.prdata[7:0] = q.stat;
				end
				`EU_ADDR_BRGL: begin
					if (wr) begin
						d.brg[7:0] = pwdata_i[7:0];
					end
					d.prdata[7:0] = q.brg[7:0];
				end
				`EU_ADDR_BRGH: begin
					if (wr) begin
						d.brg[15:8] = pwdata_i[7:0];
					end
					d.prdata[7:0] = q.brg[15:8];
				end
				`EU_ADDR_PWRC: begin
					if (wr) begin
						d.pwrc = pwdata_i[7:0];
					end
					d.prdata[7:0] = q.pwrc;
				end
				default: begin
					d.pslverr = 1'b1;
				end
			endcase
		end
		//----------------------------------------
		// Transmitter
		//----------------------------------------
		if (wr_data) begin
			// Ninth bit captured with the byte
			d.tx_buf = {q.ctrl[`EU_BIT_CTRL_TXNB], pwdata_i[7:0]};
			d.tx_full = 1'b1;
			if (dbm) begin
				d.ctrl[`EU_BIT_CTRL_TI] = 1'b0;
			end
		end
		unique case (q.txst)
			euart_pkg::EU_TX_IDLE: begin
				d.txd = 1'b1;
				d.rxoe = 1'b0;
				if (q.tx_full & tick16) begin
					d.tx_full = wr_data;
					d.txst = euart_pkg::EU_TX_SHIFT;
					d.tx_ph = 4'h0;
					d.tx_bits = 4'h0;
					if (mode == 2'b00) begin
						d.tx_sh = {3'b111, q.tx_buf[7:0]};
						d.rxoe = 1'b1;
						d.rxo = q.tx_buf[0];
					end else if (mode == 2'b01) begin
						d.tx_sh = {2'b11, q.tx_buf[7:0], 1'b0};
						d.txd = 1'b0;
					end else begin
						d.tx_sh = {1'b1, q.tx_buf[8:0], 1'b0};
						d.txd = 1'b0;
					end
					if (dbm) begin
						d.ctrl[`EU_BIT_CTRL_TI] = 1'b1;
					end
				end
			end
			euart_pkg::EU_TX_SHIFT: begin
				if (tick16) begin
					d.tx_ph = q.tx_ph + 4'h1;
					if (mode == 2'b00) begin
						d.txd = q.tx_ph[3];
					end
					if (q.tx_ph == `EU_OVS) begin
						d.tx_sh = {1'b1, q.tx_sh[10:1]};
						d.tx_bits = q.tx_bits + 4'h1;
						if (mode == 2'b00) begin
							d.rxo = q.tx_sh[1];
						end else if (~dbm && mode[1] && q.tx_bits == 4'h8) begin
							d.txd = q.ctrl[`EU_BIT_CTRL_TXNB];
						end else begin
							d.txd = q.tx_sh[1];
						end
						if (q.tx_bits == nbits - ((mode == 2'b00) ? 4'h1 : 4'h0)) begin
							tx_done = 1'b1;
						end
					end
				end
				if (tx_done) begin
					d.txst = euart_pkg::EU_TX_IDLE;
					d.txd = 1'b1;
					if (~dbm) begin
						d.ctrl[`EU_BIT_CTRL_TI] = 1'b1;
					end
				end
			end
			default: begin
				d.txst = euart_pkg::EU_TX_IDLE;
			end
		endcase
		// Back-to-back char when buffer loaded in time
		if (tx_done & q.tx_full & dbm & (mode != 2'b00)) begin
			d.txst = euart_pkg::EU_TX_SHIFT;
			d.tx_full = 1'b0;
			d.tx_ph = 4'h0;
			d.tx_bits = 4'h0;
			d.txd = 1'b0;
			frame = (mode == 2'b01) ? {2'b11, q.tx_buf[7:0], 1'b0} : {1'b1, q.tx_buf, 1'b0};
			d.tx_sh = frame;
			d.ctrl[`EU_BIT_CTRL_TI] = 1'b1;
		end
		//----------------------------------------
		// Receiver
		//----------------------------------------
		if (tick16) begin
			d.rxd_prev = rxd_i;
		end
		unique case (q.rxst)
			euart_pkg::EU_RX_IDLE: begin
				if (tick16 & q.ctrl[`EU_BIT_CTRL_REN] & (mode != 2'b00) & q.rxd_prev & ~rxd_i) begin
					d.rxst = euart_pkg::EU_RX_SHIFT;
					d.rx_ph = 4'h1;
					d.rx_bits = 4'h0;
				end
			end
			euart_pkg::EU_RX_SHIFT: begin
				if (tick16) begin
					d.rx_ph = q.rx_ph + 4'h1;
					if (q.rx_ph == 4'h7) begin
						d.rx_sh = {rxd_i, q.rx_sh[9:1]};
						d.rx_bits = q.rx_bits + 4'h1;
						if (q.rx_bits == 4'h0 && rxd_i) begin
							d.rxst = euart_pkg::EU_RX_IDLE;
						end
						if (q.rx_bits == nbits) begin
							rx_done = 1'b1;
						end
					end
				end
				if (rx_done) begin
					d.rxst = euart_pkg::EU_RX_IDLE;
					d.ctrl[`EU_BIT_CTRL_RI] = 1'b1;
					if (mode == 2'b01) begin
						d.rx_data = q.rx_sh[9:2];
						d.ctrl[`EU_BIT_CTRL_RXNB] = rxd_i;
					end else begin
						d.rx_data = q.rx_sh[8:1];
						d.ctrl[`EU_BIT_CTRL_RXNB] = q.rx_sh[9];
					end
					if (~rxd_i) begin
						d.stat[`EU_BIT_STAT_FE] = 1'b1;
					end
				end
			end
			default: begin
				d.rxst = euart_pkg::EU_RX_IDLE;
			end
		endcase
		//----------------------------------------
		// Break detection
		//----------------------------------------
		if (tick16) begin
			if (rxd_i) begin
				d.brk_ph = 4'h0;
				d.brk_bits = 4'h0;
			end else begin
				d.brk_ph = q.brk_ph + 4'h1;
				if (q.brk_ph == `EU_OVS && q.brk_bits != `EU_BREAK_BITS) begin
					d.brk_bits = q.brk_bits + 4'h1;
					if (q.brk_bits == `EU_BREAK_BITS - 4'h1) begin
						d.stat[`EU_BIT_STAT_BR] = 1'b1;
						d.brst = q.stat[`EU_BIT_STAT_BRST];
					end
				end
			end
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q <= '0;
			q.ctrl <= `EU_CTRL_RST;
			q.stat <= `EU_STAT_RST;
			q.pwrc <= `EU_PWRC_RST;
			q.txd <= 1'b1;
			q.rxd_prev <= 1'b1;
		end else begin
			q <= d;
		end
	end
	assign prdata_o = q.prdata;
	assign pready_o = q.pready;
	assign pslverr_o = q.pslverr;
	assign txd_o = q.txd;
	assign rxd_o = q.rxo;
	assign rxd_oe_o = q.rxoe;
	assign tx_irq_o = q.ctrl[`EU_BIT_CTRL_TI];
	assign rx_irq_o = q.ctrl[`EU_BIT_CTRL_RI];
	assign break_rst_o = q.brst;
	//----------------------------------------
	// Checks
	//----------------------------------------
	sequence s_apb_take;
		psel_i && penable_i && !pready_o;
	endsequence
	property p_ready_one;
		@(posedge sys_clk_i) disable iff (srst_i) s_apb_take |=> pready_o ##1 !pready_o;
	endproperty
	a_ready_one: assert property (p_ready_one) else $error("pready longer than one cycle");
	property p_txd_idle_high;
		@(posedge sys_clk_i) disable iff (srst_i)
			(q.txst == euart_pkg::EU_TX_IDLE && !tick16) |-> txd_o;
	endproperty
	a_txd_idle_high: assert property (p_txd_idle_high) else $error("txd low while idle");
	property p_brk_flag;
		@(posedge sys_clk_i) disable iff (srst_i)
			(tick16 && !rxd_i && q.brk_ph == 4'hF && q.brk_bits == 4'hA) |=> q.stat[1];
	endproperty
	a_brk_flag: assert property (p_brk_flag) else $error("break not flagged");
	property p_fe_view;
		@(posedge sys_clk_i) disable iff (srst_i)
			(rd && paddr_i == 12'h000 && q.pwrc[6]) |=> prdata_o[7] == $past(q.stat[0]);
	endproperty
	a_fe_view: assert property (p_fe_view) else $error("framing view wrong");
	property p_brst;
		@(posedge sys_clk_i) disable iff (srst_i) $rose(break_rst_o) |-> $past(q.stat[6]);
	endproperty
	a_brst: assert property (p_brst) else $error("break reset without enable");
	property p_db_ti;
		@(posedge sys_clk_i) disable iff (srst_i)
			(dbm && q.txst == euart_pkg::EU_TX_IDLE && q.tx_full && tick16 && !wr_data)
			|=> tx_irq_o;
	endproperty
	a_db_ti: assert property (p_db_ti) else $error("tx buffer ready not flagged");
	property p_sb_ti;
		@(posedge sys_clk_i) disable iff (srst_i)
			(!dbm && q.txst == euart_pkg::EU_TX_SHIFT && !tx_done && !wr) |=> $stable(tx_irq_o);
	endproperty
	a_sb_ti: assert property (p_sb_ti) else $error("tx flag moved mid frame");
	property p_tb8_buf;
		@(posedge sys_clk_i) disable iff (srst_i)
			wr_data |=> q.tx_buf[8] == $past(q.ctrl[3]);
	endproperty
	a_tb8_buf: assert property (p_tb8_buf) else $error("ninth bit not buffered");
	property p_fe_set;
		@(posedge sys_clk_i) disable iff (srst_i) (rx_done && !rxd_i) |=> q.stat[0];
	endproperty
	a_fe_set: assert property (p_fe_set) else $error("framing error missed");
endmodule

// ==== pkg/euart_params.svh ====
// Constants for the enhanced UART block
// Functional notes
// - Shift mode: data on rx pin, clock on tx pin, 8 bits LSB first, clk/16.
// - 8-bit mode: start, 8 data LSB first, stop; stop bit stored as rx ninth bit.
// - 8-bit and variable 9-bit modes use timer-1 overflow or baud generator.
// - 9-bit mode: start, 8 data, ninth from tx ninth bit, stop; ninth received.
// - Fixed 9-bit mode runs at clk/16 or clk/32, chosen by software.
// - Variable 9-bit mode frames like fixed 9-bit, differing only in rate.
// - Baud generator uses a 16-bit divisor from two byte registers.
// - Baud generator counts on the CPU clock.
// - Rate source: fixed divide, timer-1 overflow, or baud generator.
// - No timer-2 overflow rate source exists.
// - Timer-1 rate is halved when the halve select bit is clear.
// - Framing error in status; control bit 7 shows it when view select is 1.
// - Break flagged when rx is low for 11 consecutive bit times.
// - Detected break can optionally request a device reset.
// - Double buffer: next char follows with one stop bit between.
// - Double buffer disabled: transmitter is conventional single-buffered.
// - Double buffer on: tx interrupt when buffer can accept data.
// - Double buffer on: tx ninth bit buffered together with data byte.
`ifndef EUART_PARAMS_SVH
`define EUART_PARAMS_SVH
`define EU_CLK_HZ 50000000
`define EU_ADDR_CTRL 12'h000
`define EU_ADDR_DATA 12'h004
`define EU_ADDR_STAT 12'h008
`define EU_ADDR_BRGL 12'h00C
`define EU_ADDR_BRGH 12'h010
`define EU_ADDR_PWRC 12'h014
`define EU_CTRL_RST 8'h00
`define EU_STAT_RST 8'h00
`define EU_PWRC_RST 8'h00
`define EU_BRG_RST 8'h00
`define EU_BIT_CTRL_RI 0
`define EU_BIT_CTRL_TI 1
`define EU_BIT_CTRL_RXNB 2
`define EU_BIT_CTRL_TXNB 3
`define EU_BIT_CTRL_REN 4
`define EU_BIT_CTRL_MODE_LO 6
`define EU_BIT_CTRL_MODE_HI 7
`define EU_BIT_STAT_FE 0
`define EU_BIT_STAT_BR 1
`define EU_BIT_STAT_OE 2
`define EU_BIT_STAT_BRST 6
`define EU_BIT_STAT_DBM 7
`define EU_BIT_PWRC_FEVIEW 6
`define EU_BIT_PWRC_HALVE 7
`define EU_BIT_PWRC_T1SEL 0
`define EU_OVS 4'hF
`define EU_BREAK_BITS 4'hB
`endif

// ==== pkg/euart_pkg.sv ====
// Types for the enhanced UART block
package euart_pkg;
	typedef enum logic [1:0] {
		EU_MODE_SHIFT = 2'b00,
		EU_MODE_U8 = 2'b01,
		EU_MODE_U9F = 2'b10,
		EU_MODE_U9V = 2'b11
	} euart_mode_e;
	typedef enum logic [1:0] {
		EU_TX_IDLE = 2'b00,
		EU_TX_SHIFT = 2'b01
	} euart_txst_e;
	typedef enum logic [1:0] {
		EU_RX_IDLE = 2'b00,
		EU_RX_SHIFT = 2'b01
	} euart_rxst_e;
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} euart_brg_s;
	typedef struct packed {
		logic [3:0] phase;
		logic [4:0] fix_cnt;
		logic t1_half;
		logic tick16;
	} euart_rate_s;
endpackage

// ==== src/euart_brg.sv ====
// Independent 16-bit baud generator on the CPU clock
`timescale 1ns/100ps
`include "euart_params.svh"
module euart_brg (
	input wire logic sys_clk_i, // CPU clock
	input wire logic srst_i, // Sync reset
	input wire logic [15:0] divisor_i, // Combined divisor
	output logic tick_o // Oversample tick
);
	euart_pkg::euart_brg_s st_q, st_d;
	always_comb begin
		st_d = st_q;
		st_d.tick = 1'b0;
		if (st_q.cnt == 16'h0000) begin
			st_d.cnt = divisor_i;
			st_d.tick = 1'b1;
		end else begin
			st_d.cnt = st_q.cnt - 16'h0001;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign tick_o = st_q.tick;
endmodule

// ==== src/euart_rate.sv ====
// Rate selection producing the 16x oversample tick
`timescale 1ns/100ps
`include "euart_params.svh"
module euart_rate (
	input wire logic sys_clk_i, // CPU clock
	input wire logic srst_i, // Sync reset
	input wire logic [1:0] mode_i, // Serial mode
	input wire logic halve_sel_i, // Timer baud halve select
	input wire logic t1_sel_i, // 1 selects timer-1 overflow
	input wire logic t1_ovf_i, // Timer-1 overflow pulse
	input wire logic brg_tick_i, // Baud generator tick
	output logic tick16_o // Oversample tick
);
	euart_pkg::euart_rate_s st_q, st_d;
	logic src_tick;
	always_comb begin
		st_d = st_q;
		st_d.tick16 = 1'b0;
		src_tick = 1'b0;
		st_d.fix_cnt = st_q.fix_cnt + 5'h01;
		// No timer-2 source exists
		unique case (euart_pkg::euart_mode_e'(mode_i))
			euart_pkg::EU_MODE_SHIFT: begin
				src_tick = 1'b1;
			end
			euart_pkg::EU_MODE_U9F: begin
				// 16x tick at clk/16 or clk/32 bit rates
				src_tick = halve_sel_i ? 1'b1 : st_q.fix_cnt[0];
			end
			euart_pkg::EU_MODE_U8, euart_pkg::EU_MODE_U9V: begin
				if (t1_sel_i) begin
					if (t1_ovf_i) begin
						st_d.t1_half = ~st_q.t1_half;
						src_tick = halve_sel_i | st_q.t1_half;
					end
				end else begin
					src_tick = brg_tick_i;
				end
			end
		endcase
		st_d.tick16 = src_tick;
	end
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	assign tick16_o = st_q.tick16;
endmodule

// ==== testbench/euart_remote.sv ====
// Remote serial station model: frame receiver and frame sender
`timescale 1ns/100ps
module euart_remote (
	input wire logic sys_clk_i, // Bench clock
	input wire logic line_i, // Line from the block
	input int bit_clks_i, // Clocks per bit
	input int nbits_i, // Bits after start
	output logic line_o, // Line to the block
	output logic [10:0] frame_o, // Start, data, ninth, stop
	output int gap_o, // Clocks between start edges
	output logic got_o // Frame complete pulse
);
	int cyc = 0;
	int last = 0;
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
	end
	// ----------------------------------------
	// Receiver, samples at bit centres
	// ----------------------------------------
	initial begin
		line_o = 1'b1;
		got_o = 1'b0;
		frame_o = '0;
		gap_o = 0;
		forever begin
			@(posedge sys_clk_i);
			got_o <= 1'b0;
			if (line_i === 1'b0) begin
				gap_o <= cyc - last;
				last = cyc;
				frame_o <= '0;
				repeat (bit_clks_i / 2) @(posedge sys_clk_i);
				for (int i = 0; i <= nbits_i; i++) begin
					frame_o[i] <= line_i;
					if (i < nbits_i) begin
						repeat (bit_clks_i) @(posedge sys_clk_i);
					end
				end
				got_o <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Sender, LSB first, line idles high
	// ----------------------------------------
	task automatic send(input logic [11:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			line_o <= b[i];
			repeat (bit_clks_i) @(posedge sys_clk_i);
		end
		line_o <= 1'b1;
	endtask
endmodule

// ==== testbench/tb.sv ====
// Self-checking testbench for the enhanced UART block
`timescale 1ns/100ps
`include "euart_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h00000000;
	logic t1_ovf_i = 1'b0;
	logic t1_on = 1'b0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, rxd_o, rxd_oe_o, txd_o, tx_irq_o, rx_irq_o, break_rst_o;
	logic line, got, err;
	logic [10:0] frame;
	logic [10:0] exp_q[$];
	logic [31:0] rd;
	logic [7:0] d, d2;
	logic [11:0] regs[5] = '{12'h000, 12'h008, 12'h00C, 12'h010, 12'h014};
	int gap;
	int bit_clks = 48;
	int nbits = 9;
	int mismatches = 0;
	int total_checks = 0;
	integer seed = 32'h53F2CA1E;
	logic shclk_prev = 1'b1;
	logic [7:0] sh_cap = 8'h00;
	always #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		t1_ovf_i <= t1_on & ~t1_ovf_i;
	end
	// Shift-mode peripheral: capture data on rising shift clock
	always @(posedge sys_clk_i) begin
		shclk_prev <= txd_o;
		if (rxd_oe_o === 1'b1 && txd_o === 1'b1 && shclk_prev === 1'b0) begin
			sh_cap <= {rxd_o, sh_cap[7:1]};
		end
	end
	euart_top u_euart_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.rxd_i(rxd_oe_o ? rxd_o : line), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
		.t1_ovf_i(t1_ovf_i), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
		.break_rst_o(break_rst_o));
	euart_remote u_euart_remote (.sys_clk_i(sys_clk_i), .line_i(txd_o), .bit_clks_i(bit_clks),
		.nbits_i(nbits), .line_o(line), .frame_o(frame), .gap_o(gap), .got_o(got));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic complete_run();
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= a;
		pwdata_i <= wd;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge sys_clk_i);
			if (pready_o === 1'b1) break;
		end
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n == 50) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic wait_for(input int which, input int lim);
		int n;
		for (n = 0; n < lim; n++) begin
			@(posedge sys_clk_i);
			if ((which == 0 ? got : which == 1 ? tx_irq_o : rx_irq_o) === 1'b1) break;
		end
		if (n == lim) begin
			mismatches++;
			complete_run();
		end
	endtask
	task automatic tx_frame(input logic [7:0] v, input logic nb);
		exp_q.push_back(nbits == 10 ? {1'b1, nb, v, 1'b0} : {2'b01, v, 1'b0});
		apb(1'b1, `EU_ADDR_DATA, {24'h0, v});
	endtask
	task automatic tx_check();
		logic [10:0] e;
		wait_for(0, 13 * bit_clks);
		e = exp_q.pop_front();
		`CHK(frame, e)
	endtask
	task automatic rx(input logic [7:0] v, input logic nb);
		u_euart_remote.send({2'b11, nb, v, 1'b0}, nbits + 2);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		foreach (regs[i]) begin
			apb(1'b0, regs[i], 32'h0);
			`CHK(rd, 32'h00000000)
		end
		apb(1'b0, 12'h018, 32'h0);
		`CHK({err, rd}, {1'b1, 32'h00000000})
		d = $random(seed);
		apb(1'b1, `EU_ADDR_DATA, {24'h0, d});
		wait_for(1, 200);
		`CHK(sh_cap, d)
		repeat (12 * bit_clks) @(posedge sys_clk_i);
		apb(1'b1, `EU_ADDR_BRGL, 32'h02);
		apb(1'b1, `EU_ADDR_BRGH, 32'h00);
		apb(1'b1, `EU_ADDR_PWRC, 32'h80);
		apb(1'b1, `EU_ADDR_CTRL, 32'h50);
		for (int k = 0; k < 2; k++) begin
			d = $random(seed);
			tx_frame(d, 1'b1);
			repeat (5 * bit_clks) @(posedge sys_clk_i);
			`CHK(tx_irq_o, 1'b0)
			tx_check();
			wait_for(1, 2 * bit_clks);
			apb(1'b1, `EU_ADDR_CTRL, 32'h50);
		end
		d = $random(seed);
		rx(d, 1'b1);
		wait_for(2, 2 * bit_clks);
		apb(1'b0, `EU_ADDR_DATA, 32'h0);
		`CHK(rd[7:0], d)
		apb(1'b0, `EU_ADDR_CTRL, 32'h0);
		`CHK(rd[2], 1'b1)
		apb(1'b1, `EU_ADDR_CTRL, 32'h50);
		rx(8'h00, 1'b0);
		repeat (2 * bit_clks) @(posedge sys_clk_i);
		apb(1'b0, `EU_ADDR_STAT, 32'h0);
		`CHK(rd[1:0], 2'b01)
		apb(1'b1, `EU_ADDR_PWRC, 32'hC0);
		apb(1'b0, `EU_ADDR_CTRL, 32'h0);
		`CHK(rd[7], 1'b1)
		apb(1'b1, `EU_ADDR_PWRC, 32'h80);
		apb(1'b0, `EU_ADDR_CTRL, 32'h0);
		`CHK(rd[7], 1'b0)
		apb(1'b1, `EU_ADDR_STAT, 32'h40);
		u_euart_remote.send(12'h000, 12);
		repeat (2 * bit_clks) @(posedge sys_clk_i);
		apb(1'b0, `EU_ADDR_STAT, 32'h0);
		`CHK(rd[1], 1'b1)
		`CHK(break_rst_o, 1'b1)
		srst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		srst_i <= 1'b0;
		nbits = 10;
		for (int k = 0; k < 2; k++) begin
			bit_clks = 16 << k;
			apb(1'b1, `EU_ADDR_PWRC, k ? 32'h00 : 32'h80);
			d = $random(seed);
			apb(1'b1, `EU_ADDR_CTRL, {24'h0, 4'h9, d[0] ^ k[0], 3'h0});
			tx_frame(d, d[0]);
			if (k == 1) begin
				apb(1'b1, `EU_ADDR_CTRL, {24'h0, 4'h9, d[0], 3'h0});
			end
			tx_check();
		end
		t1_on <= 1'b1;
		bit_clks = 64;
		apb(1'b1, `EU_ADDR_PWRC, 32'h01);
		d = $random(seed);
		apb(1'b1, `EU_ADDR_CTRL, {24'h0, 4'hD, d[1], 3'h0});
		tx_frame(d, d[1]);
		tx_check();
		apb(1'b1, `EU_ADDR_CTRL, 32'hD0);
		rx(d, ~d[2]);
		wait_for(2, 3 * bit_clks);
		apb(1'b0, `EU_ADDR_DATA, 32'h0);
		`CHK(rd[7:0], d)
		apb(1'b0, `EU_ADDR_CTRL, 32'h0);
		`CHK(rd[2], ~d[2])
		d2 = $random(seed);
		apb(1'b1, `EU_ADDR_STAT, 32'h80);
		apb(1'b1, `EU_ADDR_CTRL, {24'h0, 4'hD, d2[0], 3'h0});
		tx_frame(d, d2[0]);
		wait_for(1, 3 * bit_clks);
		apb(1'b1, `EU_ADDR_CTRL, {24'h0, 4'hD, d2[1], 3'h0});
		tx_frame(~d, d2[1]);
		tx_check();
		tx_check();
		`CHK(gap, 11 * bit_clks)
		complete_run();
	end
endmodule
